// ### hdl/hsm_regs.sv
// register bank of the hot swap monitor: meter, alert, converter control and status
//
// Behaviour
// - six-byte energy register, read/write, resets zero
// - four-byte counter of accumulated conversions
// - alert flag sticks until host writes zero or a reboot starts
// - host writing one simulates an alert
// - pull-down bit drives alert pin low
// - reboot bit: off, reload, restart after 3.2s
// - meter reset bit holds meter at zero
// - meter halt bit freezes meter values
// - fault rise with log enable stores logs
// - gate flag zero if either gate high
// - halted converter runs once per rewrite
// - idle bit one only when halted waiting
// - busy bit high throughout nonvolatile write
// - tick wrap flag after counter overflow
// - energy wrap flag after accumulator overflow
// - first status byte bit layout
// - second status byte pin level bits
// - status register is read-only and live
// - charge mode accumulates current instead of power
`timescale 1ns/1ps
`default_nettype none
module hsm_regs #(
    parameter int unsigned REBOOT_CYCLES = hsm_pkg::REBOOT_CYC
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic alert_event,
    input wire logic alert_pin_in,
    output logic alert_pin_out,
    output logic alert_pin_oe,
    output logic alert_flag,
    input wire logic gate1_high_in,
    input wire logic gate2_high_in,
    input wire logic [2:0] gp_pin_in,
    input wire logic on_pin_in,
    input wire logic on_cmd,
    input wire logic switch_bad_cooldown_flag,
    input wire logic switch_short_flag,
    input wire logic power_good,
    input wire logic overcurrent_cooldown_flag,
    input wire logic input_low_flag,
    input wire logic input_high_flag,
    input wire logic conv_done,
    input wire logic [hsm_pkg::SAMPLE_W-1:0] power_sample,
    input wire logic [hsm_pkg::SAMPLE_W-1:0] current_sample,
    input wire logic coulomb_mode,
    output logic conv_run,
    input wire logic [7:0] fault_bits,
    input wire logic [7:0] fault_log,
    input wire logic [7:0] adc_alert_log,
    input wire logic nvm_busy,
    output logic nvm_wr_req,
    output logic [7:0] nvm_wr_fault,
    output logic [7:0] nvm_wr_alert,
    input wire logic auto_restart_cfg,
    output logic switch_off,
    output logic config_reload,
    output logic restart_req
);
    localparam int NPIN = 7;

    hsm_meter_if mif ();

    logic [NPIN-1:0] pin_s1_r;
    logic [NPIN-1:0] pin_s2_r;
    logic [NPIN-1:0] pin_raw;
    logic gate_level_flag;
    logic alert_gen_r;
    logic alert_pin_pulldown_r;
    logic meter_rst_r;
    logic meter_halt_r;
    logic flog_en_r;
    logic adc_halt_r;
    logic one_shot_r;
    logic rebooting_r;
    logic [31:0] reboot_cnt_r;
    logic config_reload_r;
    logic restart_req_r;
    logic [7:0] fault_q_r;
    logic flog_pend_r;
    logic nvm_wr_req_r;
    logic [7:0] nvm_wr_fault_r;
    logic [7:0] nvm_wr_alert_r;
    logic [7:0] rdata_r;
    logic [7:0] rd_nxt;
    logic wr_alert;
    logic wr_conv;
    logic reboot_start;
    logic reboot_end;
    logic fault_rise;
    logic nvm_busy_flag;
    logic adc_idle;
    logic [2:0] ebyte;
    logic [2:0] tbyte;
    logic [7:0] stat_hi;
    logic [7:0] stat_lo;

    ////////////////////////////////////////////////////////////////////////////////
    // pin comparators are asynchronous to ref_clk: two flops before any use
    // packed once so every stage indexes in range: gate1, gate2, on, alert, then pins 1 to 3
    assign pin_raw = {gp_pin_in, alert_pin_in, on_pin_in, gate2_high_in, gate1_high_in};
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                pin_s1_r[i] <= 1'b0;
                pin_s2_r[i] <= 1'b0;
            end else begin
                pin_s1_r[i] <= pin_raw[i];
                pin_s2_r[i] <= pin_s1_r[i];
            end
        end
    end

    // a gate above 8 V on either driver reads as zero
    assign gate_level_flag = !(pin_s2_r[0] || pin_s2_r[1]);

    ////////////////////////////////////////////////////////////////////////////////
    // address decode
    assign wr_alert = reg_wr && reg_addr == hsm_pkg::ADDR_ALERT_CTL;
    assign wr_conv = reg_wr && reg_addr == hsm_pkg::ADDR_CONV_CTL;
    assign reboot_start = wr_conv && reg_wdata[hsm_pkg::CC_REBOOT_BIT] && !rebooting_r;
    assign reboot_end = rebooting_r && reboot_cnt_r == REBOOT_CYCLES - 1;
    assign ebyte = 3'(reg_addr - hsm_pkg::ADDR_ENERGY);
    assign tbyte = 3'(reg_addr - hsm_pkg::ADDR_TICK);

    // byte strobes into the meter core
    always_comb begin
        mif.energy_we = '0;
        mif.tick_we = '0;
        if (reg_wr && reg_addr >= hsm_pkg::ADDR_ENERGY && reg_addr <= hsm_pkg::ADDR_ENERGY_LAST) begin
            mif.energy_we = hsm_pkg::ENERGY_BYTES'(1) << ebyte;
        end else if (reg_wr && reg_addr >= hsm_pkg::ADDR_TICK && reg_addr <= hsm_pkg::ADDR_TICK_LAST) begin
            mif.tick_we = hsm_pkg::TICK_BYTES'(1) << tbyte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // alert control: an internal alert in the same cycle as a host clear wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst || reboot_start) begin
            alert_gen_r <= 1'b0;
            alert_pin_pulldown_r <= 1'b0;
        end else begin
            if (alert_event) begin
                alert_gen_r <= 1'b1;
            end else if (wr_alert) begin
                alert_gen_r <= reg_wdata[hsm_pkg::ALC_GEN_BIT];
            end
            if (wr_alert) begin
                alert_pin_pulldown_r <= reg_wdata[hsm_pkg::ALC_PD_BIT];
            end
        end
    end

    // open-drain: only ever drives low
    assign alert_pin_out = 1'b0;
    assign alert_pin_oe = alert_pin_pulldown_r;
    assign alert_flag = alert_gen_r;

    ////////////////////////////////////////////////////////////////////////////////
    // converter and meter control; reboot reloads the defaults
    always_ff @(posedge ref_clk) begin
        if (sys_rst || reboot_start) begin
            meter_rst_r <= 1'b0;
            meter_halt_r <= 1'b0;
            flog_en_r <= 1'b0;
            adc_halt_r <= 1'b0;
        end else if (wr_conv) begin
            meter_rst_r <= reg_wdata[hsm_pkg::CC_MRST_BIT];
            meter_halt_r <= reg_wdata[hsm_pkg::CC_MHALT_BIT];
            flog_en_r <= reg_wdata[hsm_pkg::CC_FLOG_BIT];
            adc_halt_r <= reg_wdata[hsm_pkg::CC_HALT_BIT];
        end
    end

    // single shot: a rewrite with halt still set arms one conversion; arming beats completion
    always_ff @(posedge ref_clk) begin
        if (sys_rst || reboot_start) begin
            one_shot_r <= 1'b0;
        end else if (wr_conv && reg_wdata[hsm_pkg::CC_HALT_BIT] && adc_halt_r) begin
            one_shot_r <= 1'b1;
        end else if (conv_done || (wr_conv && !reg_wdata[hsm_pkg::CC_HALT_BIT])) begin
            one_shot_r <= 1'b0;
        end
    end

    assign conv_run = !adc_halt_r || one_shot_r;
    assign adc_idle = adc_halt_r && !one_shot_r;

    // meter core sees the chosen sample; charge mode swaps power for current
    assign mif.conv_done = conv_done;
    assign mif.sample = coulomb_mode ? current_sample : power_sample;
    assign mif.meter_rst = meter_rst_r;
    assign mif.meter_hold = meter_halt_r;
    assign mif.wdata = reg_wdata;

    hsm_meter u_meter (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .mif(mif.core)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // reboot: switch held off for the full off time, then restart if configured
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rebooting_r <= 1'b0;
            reboot_cnt_r <= 32'h0;
            config_reload_r <= 1'b0;
            restart_req_r <= 1'b0;
        end else begin
            config_reload_r <= reboot_start;
            restart_req_r <= reboot_end && auto_restart_cfg;
            if (reboot_start) begin
                rebooting_r <= 1'b1;
                reboot_cnt_r <= 32'h0;
            end else if (reboot_end) begin
                rebooting_r <= 1'b0;
            end else if (rebooting_r) begin
                reboot_cnt_r <= reboot_cnt_r + 32'h1;
            end
        end
    end

    assign switch_off = rebooting_r;
    assign config_reload = config_reload_r;
    assign restart_req = restart_req_r;

    ////////////////////////////////////////////////////////////////////////////////
    // fault logging: a new rise pends until the store is free; a rise beats the issue
    assign fault_rise = |(fault_bits & ~fault_q_r);

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            fault_q_r <= 8'h00;
            flog_pend_r <= 1'b0;
            nvm_wr_req_r <= 1'b0;
            nvm_wr_fault_r <= hsm_pkg::BYTE_RST;
            nvm_wr_alert_r <= hsm_pkg::BYTE_RST;
        end else begin
            fault_q_r <= fault_bits;
            nvm_wr_req_r <= flog_pend_r && !nvm_busy && !nvm_wr_req_r;
            if (flog_en_r && fault_rise) begin
                flog_pend_r <= 1'b1;
                nvm_wr_fault_r <= fault_log;
                nvm_wr_alert_r <= adc_alert_log;
            end else if (flog_pend_r && !nvm_busy && !nvm_wr_req_r) begin
                flog_pend_r <= 1'b0;
            end
        end
    end

    assign nvm_wr_req = nvm_wr_req_r;
    assign nvm_wr_fault = nvm_wr_fault_r;
    assign nvm_wr_alert = nvm_wr_alert_r;
    // busy covers the pending and issue cycles, so there is no gap before the store reacts
    assign nvm_busy_flag = flog_pend_r || nvm_wr_req_r || nvm_busy;

    ////////////////////////////////////////////////////////////////////////////////
    // live status bytes, nothing stored so writes cannot touch them
    assign stat_hi = {on_cmd, switch_bad_cooldown_flag, switch_short_flag, pin_s2_r[2],
                      power_good, overcurrent_cooldown_flag, input_low_flag, input_high_flag};
    assign stat_lo = {pin_s2_r[6], pin_s2_r[5], pin_s2_r[4], pin_s2_r[3], nvm_busy_flag, adc_idle,
                      mif.tick_wrap, mif.energy_wrap};

    // read mux; addresses outside this bank read zero
    always_comb begin
        rd_nxt = 8'h00;
        if (reg_addr >= hsm_pkg::ADDR_ENERGY && reg_addr <= hsm_pkg::ADDR_ENERGY_LAST) begin
            rd_nxt = mif.energy[(hsm_pkg::ENERGY_BYTES-1-int'(ebyte))*8 +: 8];
        end else if (reg_addr >= hsm_pkg::ADDR_TICK && reg_addr <= hsm_pkg::ADDR_TICK_LAST) begin
            rd_nxt = mif.ticks[(hsm_pkg::TICK_BYTES-1-int'(tbyte))*8 +: 8];
        end else if (reg_addr == hsm_pkg::ADDR_ALERT_CTL) begin
            rd_nxt = {alert_gen_r, alert_pin_pulldown_r, 6'h00};
        end else if (reg_addr == hsm_pkg::ADDR_CONV_CTL) begin
            rd_nxt = {rebooting_r, meter_rst_r, meter_halt_r, 2'h0, flog_en_r, gate_level_flag,
                      adc_halt_r};
        end else if (reg_addr == hsm_pkg::ADDR_STAT_HI) begin
            rd_nxt = stat_hi;
        end else if (reg_addr == hsm_pkg::ADDR_STAT_LO) begin
            rd_nxt = stat_lo;
        end
    end

    // read data is captured on the read strobe and held until the next one
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    sequence reboot_wr_s;
        reboot_start;
    endsequence
    sequence held_off_s;
        switch_off [*8];
    endsequence
    sequence arm_shot_s;
        wr_conv && reg_wdata[hsm_pkg::CC_HALT_BIT] && adc_halt_r;
    endsequence

    alert_sticky_a: assert property (alert_event && !reboot_start |=> alert_gen_r && alert_flag)
        else $error("alert event lost");
    alert_hold_a: assert property (alert_gen_r && !wr_alert && !reboot_start |=> alert_gen_r)
        else $error("alert flag dropped without host clear");
    alert_sim_a: assert property (wr_alert && reg_wdata[7] |=> alert_gen_r)
        else $error("host alert simulation ignored");
    pulldown_pin_a: assert property (wr_alert && !reboot_start |=> alert_pin_oe == $past(reg_wdata[6]))
        else $error("alert pin drive does not follow pull-down bit");
    reserved_read_a: assert property (reg_rd && (reg_addr == 8'h1C || reg_addr == 8'h1D)
        |=> reg_rdata[5:0] == 6'h00 || $past(reg_addr) == 8'h1D && reg_rdata[4:3] == 2'h0)
        else $error("reserved bits read nonzero");
    reboot_off_a: assert property (reboot_wr_s |=> config_reload ##0 held_off_s)
        else $error("reboot did not hold switch off");
    reboot_end_a: assert property (reboot_end |=> !switch_off && restart_req == $past(auto_restart_cfg))
        else $error("reboot did not end correctly");
    log_store_a: assert property (flog_en_r && fault_rise |=> flog_pend_r ##1 nvm_busy_flag)
        else $error("fault rise not logged");
    single_shot_a: assert property (one_shot_r && conv_done && !wr_conv |=> !conv_run && adc_idle)
        else $error("single shot did not stop after one conversion");
    shot_arm_a: assert property (arm_shot_s |=> conv_run && !adc_idle)
        else $error("rewrite with halt did not start a conversion");
    busy_flag_a: assert property (reg_rd && reg_addr == hsm_pkg::ADDR_STAT_LO && (nvm_busy || nvm_wr_req_r)
        |=> reg_rdata[hsm_pkg::ST_BUSY_BIT])
        else $error("busy low during store request");
endmodule : hsm_regs
`default_nettype wire

// ### pkg/hsm_pkg.sv
// constants shared by the hot swap meter register bank
`default_nettype none
package hsm_pkg;
    // datapath widths
    localparam int ENERGY_W = 48;
    localparam int TICK_W = 32;
    localparam int SAMPLE_W = 16;
    localparam int ENERGY_BYTES = 6;
    localparam int TICK_BYTES = 4;
    localparam int SYNC_STAGES = 2;

    // byte addresses; the lowest address of a multi-byte register is its top byte
    localparam logic [7:0] ADDR_ENERGY = 8'h12;
    localparam logic [7:0] ADDR_ENERGY_LAST = 8'h17;
    localparam logic [7:0] ADDR_TICK = 8'h18;
    localparam logic [7:0] ADDR_TICK_LAST = 8'h1B;
    localparam logic [7:0] ADDR_ALERT_CTL = 8'h1C;
    localparam logic [7:0] ADDR_CONV_CTL = 8'h1D;
    localparam logic [7:0] ADDR_STAT_HI = 8'h1E;
    localparam logic [7:0] ADDR_STAT_LO = 8'h1F;

    // alert_pin_control fields
    localparam int ALC_GEN_BIT = 7;
    localparam int ALC_PD_BIT = 6;
    // converter_meter_control fields
    localparam int CC_REBOOT_BIT = 7;
    localparam int CC_MRST_BIT = 6;
    localparam int CC_MHALT_BIT = 5;
    localparam int CC_FLOG_BIT = 2;
    localparam int CC_GATE_BIT = 1;
    localparam int CC_HALT_BIT = 0;
    // live_condition_flags low byte fields
    localparam int ST_BUSY_BIT = 3;
    localparam int ST_IDLE_BIT = 2;
    localparam int ST_TWRAP_BIT = 1;
    localparam int ST_AWRAP_BIT = 0;

    // reset values
    localparam logic [ENERGY_W-1:0] ENERGY_RST = 48'h0;
    localparam logic [TICK_W-1:0] TICK_RST = 32'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // reboot off time
    localparam int CLK_HZ = 25000000;
    localparam int REBOOT_TIME_MS = 3200;
    localparam int unsigned REBOOT_CYC = REBOOT_TIME_MS * (CLK_HZ / 1000);
endpackage : hsm_pkg
`default_nettype wire

// ### pkg/hsm_meter_if.sv
// interface between the register bank and the energy/tick meter core
`timescale 1ns/1ps
`default_nettype none
interface hsm_meter_if;
    logic conv_done;
    logic [hsm_pkg::SAMPLE_W-1:0] sample;
    logic meter_rst;
    logic meter_hold;
    logic [hsm_pkg::ENERGY_BYTES-1:0] energy_we;
    logic [hsm_pkg::TICK_BYTES-1:0] tick_we;
    logic [7:0] wdata;
    logic [hsm_pkg::ENERGY_W-1:0] energy;
    logic [hsm_pkg::TICK_W-1:0] ticks;
    logic energy_wrap;
    logic tick_wrap;

    modport ctl (output conv_done, sample, meter_rst, meter_hold, energy_we, tick_we, wdata,
                 input energy, ticks, energy_wrap, tick_wrap);
    modport core (input conv_done, sample, meter_rst, meter_hold, energy_we, tick_we, wdata,
                  output energy, ticks, energy_wrap, tick_wrap);
endinterface : hsm_meter_if
`default_nettype wire

// ### hdl/hsm_meter.sv
// energy accumulator and conversion tick counter
`timescale 1ns/1ps
`default_nettype none
module hsm_meter (
    input wire logic ref_clk,
    input wire logic sys_rst,
    hsm_meter_if.core mif
);
    logic [hsm_pkg::ENERGY_W-1:0] energy_r;
    logic [hsm_pkg::TICK_W-1:0] ticks_r;
    logic [hsm_pkg::ENERGY_W-1:0] energy_wr_val;
    logic [hsm_pkg::TICK_W-1:0] ticks_wr_val;
    logic [hsm_pkg::ENERGY_W:0] energy_sum;
    logic [hsm_pkg::TICK_W:0] ticks_sum;
    logic energy_wrap_r;
    logic tick_wrap_r;
    logic step;

    ////////////////////////////////////////////////////////////////////////////////
    // host byte writes merged into the live value, byte 0 being the top byte
    for (genvar i = 0; i < hsm_pkg::ENERGY_BYTES; i++) begin : g_ebyte
        assign energy_wr_val[(hsm_pkg::ENERGY_BYTES-1-i)*8 +: 8] =
            mif.energy_we[i] ? mif.wdata : energy_r[(hsm_pkg::ENERGY_BYTES-1-i)*8 +: 8];
    end
    for (genvar i = 0; i < hsm_pkg::TICK_BYTES; i++) begin : g_tbyte
        assign ticks_wr_val[(hsm_pkg::TICK_BYTES-1-i)*8 +: 8] =
            mif.tick_we[i] ? mif.wdata : ticks_r[(hsm_pkg::TICK_BYTES-1-i)*8 +: 8];
    end

    // one accumulation step per finished conversion unless frozen
    assign step = mif.conv_done && !mif.meter_hold;
    assign energy_sum = {1'b0, energy_r} + {{(hsm_pkg::ENERGY_W+1-hsm_pkg::SAMPLE_W){1'b0}}, mif.sample};
    assign ticks_sum = {1'b0, ticks_r} + {{hsm_pkg::TICK_W{1'b0}}, 1'b1};

    // energy accumulator: reset dominates, a host write beats a sample in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst || mif.meter_rst) begin
            energy_r <= hsm_pkg::ENERGY_RST;
        end else if (|mif.energy_we) begin
            energy_r <= energy_wr_val;
        end else if (step) begin
            energy_r <= energy_sum[hsm_pkg::ENERGY_W-1:0];
        end
    end

    // tick counter follows the same priorities as the accumulator
    always_ff @(posedge ref_clk) begin
        if (sys_rst || mif.meter_rst) begin
            ticks_r <= hsm_pkg::TICK_RST;
        end else if (|mif.tick_we) begin
            ticks_r <= ticks_wr_val;
        end else if (step) begin
            ticks_r <= ticks_sum[hsm_pkg::TICK_W-1:0];
        end
    end

    // sticky wrap flags, cleared only with the meter itself
    always_ff @(posedge ref_clk) begin
        if (sys_rst || mif.meter_rst) begin
            energy_wrap_r <= 1'b0;
            tick_wrap_r <= 1'b0;
        end else begin
            if (step && !(|mif.energy_we) && energy_sum[hsm_pkg::ENERGY_W]) begin
                energy_wrap_r <= 1'b1;
            end
            if (step && !(|mif.tick_we) && ticks_sum[hsm_pkg::TICK_W]) begin
                tick_wrap_r <= 1'b1;
            end
        end
    end

    assign mif.energy = energy_r;
    assign mif.ticks = ticks_r;
    assign mif.energy_wrap = energy_wrap_r;
    assign mif.tick_wrap = tick_wrap_r;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    meter_clear_a: assert property (mif.meter_rst |=> energy_r == '0 && ticks_r == '0)
        else $error("meter not cleared while reset bit set");
    meter_freeze_a: assert property (mif.meter_hold && !mif.meter_rst && !(|mif.energy_we) && !(|mif.tick_we)
        |=> $stable(energy_r) && $stable(ticks_r))
        else $error("meter moved while halted");
    tick_step_a: assert property (step && !mif.meter_rst && !(|mif.tick_we)
        |=> ticks_r == $past(ticks_r) + 32'h1)
        else $error("tick counter did not advance by one");
    energy_step_a: assert property (step && !mif.meter_rst && !(|mif.energy_we)
        |=> energy_r == $past(energy_r) + {32'h0, $past(mif.sample)})
        else $error("accumulator did not add the sample");
    tick_wrap_a: assert property (step && !mif.meter_rst && !(|mif.tick_we) && (&ticks_r)
        |=> tick_wrap_r && ticks_r == '0)
        else $error("tick wrap not flagged");
endmodule : hsm_meter
`default_nettype wire

// ### verif/hsm_nvm_model.sv
// behavioural nonvolatile store that stays busy for a while after each write request
`timescale 1ns/1ps
`default_nettype none
module hsm_nvm_model (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic nvm_wr_req,
    input wire logic slow,
    output logic nvm_busy
);
    logic [3:0] busy_cnt_r;
    // the slow setting keeps the store busy long enough for the bench to read the busy flag
    always_ff @(posedge ref_clk) begin
        if (sys_rst) busy_cnt_r <= 4'h0;
        else if (nvm_wr_req) busy_cnt_r <= slow ? 4'hC : 4'h3;
        else if (busy_cnt_r != 4'h0) busy_cnt_r <= busy_cnt_r - 4'h1;
    end
    assign nvm_busy = (busy_cnt_r != 4'h0);
endmodule : hsm_nvm_model
`default_nettype wire

// ### verif/tb_hsm_regs.sv
// self-checking bench for the hot swap meter register bank
`timescale 1ns/1ps
`default_nettype none
module tb_hsm_regs;
    logic ref_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_pend = 1'b0;
    logic alert_event = 1'b0, alert_pin_in = 1'b1, g1 = 1'b0, g2 = 1'b0, conv_done = 1'b0, coulomb_mode = 1'b0;
    logic slow = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, fault_bits = 8'h00, fault_log = 8'h00, live = 8'h00;
    logic [2:0] gp_pin_in = 3'h0;
    logic [15:0] psamp = 16'h0000, csamp = 16'h0000, acc, lfsr_r = 16'hF453;
    logic [7:0] reg_rdata, nvm_wr_fault, nvm_wr_alert;
    logic alert_pin_oe, conv_run, nvm_busy, nvm_wr_req, switch_off;
    logic alert_pin_out, alert_flag, cfg_reload, rst_req;
    logic [7:0] exp_q[$];
    int failures = 0, tests_run = 0;
    hsm_regs #(.REBOOT_CYCLES(16)) u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert_event(alert_event),
        .alert_pin_in(alert_pin_in), .alert_pin_out(alert_pin_out), .alert_pin_oe(alert_pin_oe),
        .alert_flag(alert_flag),
        .gate1_high_in(g1), .gate2_high_in(g2), .gp_pin_in(gp_pin_in), .on_pin_in(live[4]), .on_cmd(live[7]),
        .switch_bad_cooldown_flag(live[6]), .switch_short_flag(live[5]), .power_good(live[3]),
        .overcurrent_cooldown_flag(live[2]), .input_low_flag(live[1]), .input_high_flag(live[0]),
        .conv_done(conv_done), .power_sample(psamp), .current_sample(csamp), .coulomb_mode(coulomb_mode),
        .conv_run(conv_run), .fault_bits(fault_bits), .fault_log(fault_log), .adc_alert_log(~fault_log),
        .nvm_busy(nvm_busy), .nvm_wr_req(nvm_wr_req), .nvm_wr_fault(nvm_wr_fault), .nvm_wr_alert(nvm_wr_alert),
        .auto_restart_cfg(1'b1), .switch_off(switch_off), .config_reload(cfg_reload), .restart_req(rst_req));
    hsm_nvm_model u_nvm (.ref_clk(ref_clk), .sys_rst(sys_rst), .nvm_wr_req(nvm_wr_req), .slow(slow), .nvm_busy(nvm_busy));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : wr
    // the expected byte is queued now and compared when the read data comes back
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        exp_q.push_back(e);
        @(negedge ref_clk);
        reg_rd = 1'b0;
    endtask : rd
    task automatic cv(input logic cm);
        @(negedge ref_clk);
        lfsr_r = lfsr_next(lfsr_r);
        {psamp, csamp, coulomb_mode, conv_done} = {lfsr_r | 16'h0001, ~lfsr_r, cm, 1'b1};
        @(negedge ref_clk);
        conv_done = 1'b0;
    endtask : cv
    task automatic report_and_stop;
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    ////////////////////////////////////////////////////////////////////////////////
    // read data is valid one cycle after the read strobe is taken
    always @(posedge ref_clk) rd_pend <= reg_rd;
    always @(negedge ref_clk) begin
        if (rd_pend) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    end
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (10) @(negedge ref_clk);
        sys_rst = 1'b0;
        rd(8'h12, 8'h00);
        rd(8'h1B, 8'h00);
        rd(8'h1D, 8'h02);
        wr(8'h1C, 8'hFF);
        rd(8'h1C, 8'hC0);
        chk("alert_pin_oe", 8'h01, {7'h0, alert_pin_oe});
        chk("alert_pin_out", 8'h00, {7'h0, alert_pin_out});
        wr(8'h1C, 8'h00);
        rd(8'h1C, 8'h00);
        @(negedge ref_clk) alert_event = 1'b1;
        @(negedge ref_clk) alert_event = 1'b0;
        rd(8'h1C, 8'h80);
        chk("alert_flag", 8'h01, {7'h0, alert_flag});
        cv(1'b0);
        acc = psamp;
        cv(1'b1);
        acc = acc + csamp;
        rd(8'h1B, 8'h02);
        rd(8'h17, acc[7:0]);
        rd(8'h16, acc[15:8]);
        wr(8'h1D, 8'h20);
        cv(1'b0);
        rd(8'h1B, 8'h02);
        rd(8'h17, acc[7:0]);
        lfsr_r = lfsr_next(lfsr_r);
        {live, gp_pin_in} = {lfsr_r[7:0], lfsr_r[10:8]};
        for (logic [7:0] a = 8'h12; a < 8'h1C; a++) wr(a, 8'hFF);
        wr(8'h1D, 8'h00);
        cv(1'b0);
        rd(8'h1E, live);
        wr(8'h1E, 8'h00);
        rd(8'h1E, live);
        rd(8'h1F, {gp_pin_in, 5'h13});
        wr(8'h1D, 8'h40);
        rd(8'h17, 8'h00);
        rd(8'h1F, {gp_pin_in, 5'h10});
        wr(8'h1D, 8'h01);
        chk("conv_run", 8'h00, {7'h0, conv_run});
        rd(8'h1F, {gp_pin_in, 5'h14});
        wr(8'h1D, 8'h01);
        chk("conv_run", 8'h01, {7'h0, conv_run});
        cv(1'b0);
        @(negedge ref_clk);
        chk("conv_run", 8'h00, {7'h0, conv_run});
        wr(8'h1D, 8'h04);
        slow = 1'b1;
        @(negedge ref_clk) {fault_log, fault_bits} = {lfsr_r[15:8], 8'h01};
        for (int i = 0; i < 20 && nvm_wr_req !== 1'b1; i++) @(negedge ref_clk);
        chk("nvm_wr_fault", fault_log, nvm_wr_fault);
        chk("nvm_wr_alert", ~fault_log, nvm_wr_alert);
        rd(8'h1F, {gp_pin_in, 5'h18});
        wr(8'h1D, 8'h80);
        chk("switch_off", 8'h01, {7'h0, switch_off});
        chk("config_reload", 8'h01, {7'h0, cfg_reload});
        // off time is the 16 cycles given to the instance: still off on the 16th, released after it
        repeat (15) @(negedge ref_clk);
        chk("switch_off", 8'h01, {7'h0, switch_off});
        @(negedge ref_clk);
        chk("switch_off", 8'h00, {7'h0, switch_off});
        chk("restart_req", 8'h01, {7'h0, rst_req});
        // gate levels pass the two-flop synchroniser before the read can see them
        g1 = 1'b1;
        repeat (2) @(negedge ref_clk);
        rd(8'h1D, 8'h00);
        {g1, g2} = 2'h1;
        repeat (2) @(negedge ref_clk);
        rd(8'h1D, 8'h00);
        // let the last read be compared before the verdict
        @(negedge ref_clk);
        report_and_stop();
    end
endmodule : tb_hsm_regs
`default_nettype wire
